// ---- pdr_pkg.sv ----
// shared constants for the divider register port and its serial host
package pdr_pkg;

    // ==========================================
    // word layout
    localparam int          WORD_W        = 24;
    localparam int          SEL_W         = 3;
    localparam int          NUM_REGS      = 8;
    localparam int          CNT_W         = 5;
    localparam int          SEL_LSB       = 0;
    localparam int          SEL_MSB       = 2;
    localparam int          DM_BIT        = 10;
    localparam int          RATIO_LSB     = 3;
    localparam int          RATIO_MSB     = 9;
    localparam int          MOD_LSB       = 3;
    localparam int          MOD_MSB       = 13;
    localparam int          FRAC_LSB      = 3;
    localparam int          FRAC_MSB      = 13;
    localparam int          INT_USED_MSB  = 10;
    localparam int          VCO_EN_LSB    = 17;
    localparam int          VCO_EN_MSB    = 20;
    localparam logic [4:0]  FRAME_BITS    = 5'd24;

    // ==========================================
    // register select codes
    localparam logic [2:0]  SEL_INT       = 3'h0;
    localparam logic [2:0]  SEL_MOD       = 3'h1;
    localparam logic [2:0]  SEL_FRAC      = 3'h2;
    localparam logic [2:0]  SEL_DITHER    = 3'h3;
    localparam logic [2:0]  SEL_CHARGE    = 3'h4;
    localparam logic [2:0]  SEL_LOPATH    = 3'h5;
    localparam logic [2:0]  SEL_VCO       = 3'h6;
    localparam logic [2:0]  SEL_EXTVCO    = 3'h7;

    // ==========================================
    // power-up words
    localparam logic [23:0] RST_INT       = 24'h00_01C0;
    localparam logic [23:0] RST_MOD       = 24'h00_3001;
    localparam logic [23:0] RST_FRAC      = 24'h00_1802;
    localparam logic [23:0] RST_DITHER    = 24'h10_000B;
    localparam logic [23:0] RST_CHARGE    = 24'h00_0004;
    localparam logic [23:0] RST_LOPATH    = 24'h00_0005;
    localparam logic [23:0] RST_VCO       = 24'h1E_0006;
    localparam logic [23:0] RST_EXTVCO    = 24'h00_0007;
    localparam logic [10:0] RST_MODULUS   = 11'h600;

    // ==========================================
    // legal field ranges
    localparam logic [6:0]  RATIO_MIN_INT  = 7'd21;
    localparam logic [6:0]  RATIO_MAX_INT  = 7'd123;
    localparam logic [6:0]  RATIO_MIN_FRAC = 7'd24;
    localparam logic [6:0]  RATIO_MAX_FRAC = 7'd119;
    localparam logic [10:0] MOD_MIN        = 11'd1;

    // ==========================================
    // link timing
    localparam int          CLK_PERIOD_NS  = 50;
    localparam int          LINK_PERIOD_NS = 400;
    localparam int          HALF_CYCLES    = (LINK_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0]  HALF_LAST      = 4'(HALF_CYCLES - 1);

    // ==========================================
    // host register map (apb byte addresses)
    localparam logic [7:0]  HOST_WORD_OFS  = 8'h00;
    localparam logic [7:0]  HOST_STAT_OFS  = 8'h04;
    localparam int          ST_BUSY        = 0;
    localparam int          ST_INIT_DONE   = 1;
    localparam int          ST_RANGE_ERR   = 2;
    localparam int          ST_ORDER_ERR   = 3;
    localparam int          ST_LOOP_OFF    = 4;

    typedef enum logic [1:0]
    {
        PDR_IDLE  = 2'b00,
        PDR_LOW   = 2'b01,
        PDR_HIGH  = 2'b11,
        PDR_LATCH = 2'b10
    } pdr_state_t;

endpackage

// ---- pdr_spi_if.sv ----
// three-wire serial link between host and divider register port
`timescale 1ns/10ps
interface pdr_spi_if;
    logic sclk;
    logic sdata;
    logic le;

    modport dev
    (
        input sclk,
        input sdata,
        input le
    );

    modport host
    (
        output sclk,
        output sdata,
        output le
    );
endinterface

// ---- pdr_sync.sv ----
// two-flop synchroniser for the serial link pins
`timescale 1ns/10ps
module pdr_sync
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // pins
    input  wire logic [2:0] pinIn,
    output logic      [2:0] pinSync
);
    logic [2:0] stage1;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stage1  <= 3'h0;
            pinSync <= 3'h0;
        end
        else
        begin
            stage1  <= pinIn;
            pinSync <= stage1;
        end
    end
endmodule

// ---- pdr_dev.sv ----
// divider register port: serial word receiver and eight configuration registers
`timescale 1ns/10ps
module pdr_dev
    import pdr_pkg::*;
(
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // serial link
    pdr_spi_if.dev                spi,
    // register contents
    output logic [7:0][23:0]      cfgWords,
    output logic                  divideModeSelect,
    output logic [6:0]            intRatio,
    output logic [10:0]           fractionModulus,
    output logic [10:0]           fracNumerator,
    // status
    output logic                  loopEnable,
    output logic                  allWritten,
    output logic                  wordLoaded,
    output logic                  frameError
);
    // ==========================================
    // pin capture
    logic [2:0]  pinSync;
    logic        sclkPrev;
    logic        lePrev;
    logic        sclkRise;
    logic        leRise;
    logic [23:0] shiftReg;
    logic [4:0]  bitCnt;
    logic [7:0]  written;
    logic [2:0]  sel;

    pdr_sync u_sync
    (
        .clk     (clk),
        .rst_n   (rst_n),
        .pinIn   ({spi.le, spi.sclk, spi.sdata}),
        .pinSync (pinSync)
    );

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sclkPrev <= 1'b0;
            lePrev   <= 1'b0;
        end
        else
        begin
            sclkPrev <= pinSync[1];
            lePrev   <= pinSync[2];
        end
    end

    assign sclkRise = pinSync[1] & ~sclkPrev;
    assign leRise   = pinSync[2] & ~lePrev;
    assign sel      = shiftReg[SEL_MSB:SEL_LSB];

    // ==========================================
    // shifter, msb first
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            shiftReg <= 24'h00_0000;
            bitCnt   <= 5'd0;
        end
        else if (leRise)
        begin
            bitCnt <= 5'd0;
        end
        else if (sclkRise && !pinSync[2])
        begin
            shiftReg <= {shiftReg[22:0], pinSync[0]};
            if (bitCnt != 5'd31)
            begin
                bitCnt <= bitCnt + 5'd1;
            end
        end
    end

    // ==========================================
    // register file
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfgWords[SEL_INT]    <= RST_INT;
            cfgWords[SEL_MOD]    <= RST_MOD;
            cfgWords[SEL_FRAC]   <= RST_FRAC;
            cfgWords[SEL_DITHER] <= RST_DITHER;
            cfgWords[SEL_CHARGE] <= RST_CHARGE;
            cfgWords[SEL_LOPATH] <= RST_LOPATH;
            cfgWords[SEL_VCO]    <= RST_VCO;
            cfgWords[SEL_EXTVCO] <= RST_EXTVCO;
        end
        else if (leRise && bitCnt == FRAME_BITS)
        begin
            // the select code routes the word to its slot, in any order
            cfgWords[sel] <= shiftReg;
        end
    end

    // ==========================================
    // load status
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            written    <= 8'h00;
            allWritten <= 1'b0;
            wordLoaded <= 1'b0;
            frameError <= 1'b0;
        end
        else
        begin
            wordLoaded <= leRise && bitCnt == FRAME_BITS;
            frameError <= leRise && bitCnt != FRAME_BITS;
            if (leRise && bitCnt == FRAME_BITS)
            begin
                written[sel] <= 1'b1;
            end
            allWritten <= &written;
        end
    end

    // ==========================================
    // loop enable, dropped when the vco enable bits are all clear
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            loopEnable <= |RST_VCO[VCO_EN_MSB:VCO_EN_LSB];
        end
        else if (leRise && bitCnt == FRAME_BITS && sel == SEL_VCO)
        begin
            loopEnable <= |shiftReg[VCO_EN_MSB:VCO_EN_LSB];
        end
    end

    // divider terms: vco = 2 x pfd x (ratio + numerator / modulus), fracNumerator driven from the frac word in both divide modes
    assign divideModeSelect = cfgWords[SEL_INT][DM_BIT];
    assign intRatio         = cfgWords[SEL_INT][RATIO_MSB:RATIO_LSB];
    assign fractionModulus  = cfgWords[SEL_MOD][MOD_MSB:MOD_LSB];
    assign fracNumerator    = cfgWords[SEL_FRAC][FRAC_MSB:FRAC_LSB];
endmodule

// ---- pdr_host.sv ----
// serial host: takes words over apb and shifts them to the divider register port
//
// Added by the designer: the APB register port.
`timescale 1ns/10ps
module pdr_host
    import pdr_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // serial link
    pdr_spi_if.host          spi
);
    // ==========================================
    // word checks
    function automatic logic wordLegal(input logic [23:0] w, input logic [10:0] modulus);
        logic [6:0]  ratio;
        logic [10:0] field;
        ratio = w[RATIO_MSB:RATIO_LSB];
        field = w[MOD_MSB:MOD_LSB];
        case (w[SEL_MSB:SEL_LSB])
            SEL_INT:
                wordLegal = w[DM_BIT] ? (ratio >= RATIO_MIN_INT && ratio <= RATIO_MAX_INT)
                                      : (ratio >= RATIO_MIN_FRAC && ratio <= RATIO_MAX_FRAC);
            SEL_MOD:
                wordLegal = field >= MOD_MIN;
            SEL_FRAC:
                wordLegal = field < modulus;
            default:
                wordLegal = 1'b1;
        endcase
    endfunction

    function automatic logic [23:0] wordClean(input logic [23:0] w);
        if (w[SEL_MSB:SEL_LSB] == SEL_INT)
        begin
            wordClean = {13'h0000, w[INT_USED_MSB:0]};
        end
        else
        begin
            wordClean = w;
        end
    endfunction

    // ==========================================
    // apb decode
    pdr_state_t  state;
    logic [23:0] shiftReg;
    logic [4:0]  bitCnt;
    logic [3:0]  halfCnt;
    logic [10:0] modShadow;
    logic [2:0]  nextInit;
    logic        initDone;
    logic        rangeError;
    logic        orderError;
    logic        loopOff;
    logic        busy;
    logic        acc;
    logic        wordWr;
    logic        statWr;
    logic        start;
    logic        legal;
    logic [23:0] inWord;
    logic [23:0] cleanWord;

    assign busy   = state != PDR_IDLE;
    assign acc    = psel && penable && pready;
    assign wordWr = acc && pwrite && paddr == HOST_WORD_OFS;
    assign statWr = acc && pwrite && paddr == HOST_STAT_OFS;
    assign inWord = pwdata[23:0];
    assign cleanWord = wordClean(inWord);
    assign legal  = wordLegal(inWord, modShadow);
    assign start  = wordWr && !busy && legal;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= psel && !penable && !pready;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (psel && !penable)
            begin
                case (paddr)
                    HOST_WORD_OFS:
                        pslverr <= pwrite && busy;
                    HOST_STAT_OFS:
                    begin
                        prdata[ST_BUSY]      <= busy;
                        prdata[ST_INIT_DONE] <= initDone;
                        prdata[ST_RANGE_ERR] <= rangeError;
                        prdata[ST_ORDER_ERR] <= orderError;
                        prdata[ST_LOOP_OFF]  <= loopOff;
                    end
                    default:
                        pslverr <= 1'b1;
                endcase
            end
        end
    end

    // ==========================================
    // status flags, a new event beats a clear
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rangeError <= 1'b0;
            orderError <= 1'b0;
        end
        else
        begin
            rangeError <= (wordWr && !busy && !legal)
                        | (rangeError & ~(statWr & pwdata[ST_RANGE_ERR]));
            orderError <= (start && !initDone && inWord[SEL_MSB:SEL_LSB] != nextInit)
                        | (orderError & ~(statWr & pwdata[ST_ORDER_ERR]));
        end
    end

    // ==========================================
    // first-pass tracking and shadows
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            nextInit  <= SEL_EXTVCO;
            initDone  <= 1'b0;
            modShadow <= RST_MODULUS;
            loopOff   <= ~|RST_VCO[VCO_EN_MSB:VCO_EN_LSB];
        end
        else if (start)
        begin
            if (!initDone && inWord[SEL_MSB:SEL_LSB] == nextInit)
            begin
                if (nextInit == SEL_INT)
                begin
                    initDone <= 1'b1;
                end
                else
                begin
                    nextInit <= nextInit - 3'd1;
                end
            end
            if (inWord[SEL_MSB:SEL_LSB] == SEL_MOD)
            begin
                modShadow <= inWord[MOD_MSB:MOD_LSB];
            end
            if (inWord[SEL_MSB:SEL_LSB] == SEL_VCO)
            begin
                loopOff <= ~|inWord[VCO_EN_MSB:VCO_EN_LSB];
            end
        end
    end

    // ==========================================
    // serial frame engine
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state     <= PDR_IDLE;
            shiftReg  <= 24'h00_0000;
            bitCnt    <= 5'd0;
            halfCnt   <= 4'd0;
            spi.sclk  <= 1'b0;
            spi.sdata <= 1'b0;
            spi.le    <= 1'b0;
        end
        else
        begin
            case (state)
                PDR_IDLE:
                begin
                    if (start)
                    begin
                        shiftReg  <= cleanWord;
                        spi.sdata <= cleanWord[23];
                        bitCnt    <= FRAME_BITS - 5'd1;
                        halfCnt   <= 4'd0;
                        state     <= PDR_LOW;
                    end
                end
                PDR_LOW:
                begin
                    halfCnt <= halfCnt + 4'd1;
                    if (halfCnt == HALF_LAST)
                    begin
                        halfCnt  <= 4'd0;
                        spi.sclk <= 1'b1;
                        state    <= PDR_HIGH;
                    end
                end
                PDR_HIGH:
                begin
                    halfCnt <= halfCnt + 4'd1;
                    if (halfCnt == HALF_LAST)
                    begin
                        halfCnt  <= 4'd0;
                        spi.sclk <= 1'b0;
                        if (bitCnt == 5'd0)
                        begin
                            spi.le <= 1'b1;
                            state  <= PDR_LATCH;
                        end
                        else
                        begin
                            bitCnt    <= bitCnt - 5'd1;
                            shiftReg  <= {shiftReg[22:0], 1'b0};
                            spi.sdata <= shiftReg[22];
                            state     <= PDR_LOW;
                        end
                    end
                end
                PDR_LATCH:
                begin
                    halfCnt <= halfCnt + 4'd1;
                    if (halfCnt == HALF_LAST)
                    begin
                        halfCnt   <= 4'd0;
                        spi.le    <= 1'b0;
                        spi.sdata <= 1'b0;
                        state     <= PDR_IDLE;
                    end
                end
                default:
                    state <= PDR_IDLE;
            endcase
        end
    end
endmodule

// ---- pdr_sva.sv ----
// link timing and load checks for the divider register port
`timescale 1ns/10ps
module pdr_sva
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // serial link
    input wire logic sclk,
    input wire logic sdata,
    input wire logic le,
    // device status
    input wire logic wordLoaded,
    input wire logic frameError
);
    // ==========================================
    // sclk rises since the last load strobe
    logic       sclkLast;
    logic [5:0] riseCnt;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sclkLast <= 1'h0;
            riseCnt  <= 6'h00;
        end
        else
        begin
            sclkLast <= sclk;
            if (le)
                riseCnt <= 6'h00;
            else if (sclk && !sclkLast)
                riseCnt <= riseCnt + 6'h01;
        end
    end

    // ==========================================
    // assertions
    a_bit_count: assert property ($rose(le) |-> riseCnt == 6'h18)
        else $error("load strobe after a wrong number of clock rises");
    a_le_width: assert property ($rose(le) |-> le[*4] ##1 !le)
        else $error("load strobe not four cycles wide");
    a_le_on_fall: assert property ($rose(le) |-> $fell(sclk))
        else $error("load strobe not raised as the clock falls");
    a_sclk_high: assert property ($rose(sclk) |-> sclk[*4] ##1 !sclk)
        else $error("serial clock high half not four cycles");
    a_sclk_low: assert property ($fell(sclk) |-> !sclk[*4])
        else $error("serial clock low half shorter than four cycles");
    a_data_steady: assert property (sclk |-> $stable(sdata))
        else $error("serial data moved while the clock was high");
    a_idle_after: assert property ($fell(le) |-> !sclk && !sdata)
        else $error("link not idle after the load strobe");
    a_word_stored: assert property ($rose(le) |-> !frameError[*2] ##[0:4] wordLoaded)
        else $error("good frame not stored");
    a_load_pulse: assert property (wordLoaded |=> !wordLoaded)
        else $error("word loaded flag longer than one cycle");
endmodule

// ---- pdr_bench.sv ----
// self-checking bench: serial host and divider register port joined by the link
`timescale 1ns/10ps
module pdr_bench import pdr_pkg::*;;
    // ==========================================
    // signals
    logic             clk;
    logic             rst_n;
    logic             psel;
    logic             penable;
    logic             pwrite;
    logic [7:0]       paddr;
    logic [31:0]      pwdata;
    logic             pready;
    logic [31:0]      prdata;
    logic             pslverr;
    logic [7:0][23:0] cfgWords;
    logic [7:0][23:0] badWords;
    logic [7:0][23:0] expW;
    logic             divideModeSelect;
    logic [6:0]       intRatio;
    logic [10:0]      fractionModulus;
    logic [10:0]      fracNumerator;
    logic             loopEnable;
    logic             allWritten;
    logic             wordLoaded;
    logic             frameError;
    logic             badError;
    logic             badLoaded;
    int               bad_count;
    int               checks_done;
    pdr_spi_if        link ();
    pdr_spi_if        badLink ();

    pdr_host pdr_host_i (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
        .pslverr, .spi(link));
    pdr_dev pdr_dev_i (.clk, .rst_n, .spi(link), .cfgWords, .divideModeSelect, .intRatio,
        .fractionModulus, .fracNumerator, .loopEnable, .allWritten, .wordLoaded, .frameError);
    // second device fed by a driver that sends 23-, 25- and 24-bit frames
    pdr_dev pdr_dev_fault_i (.clk, .rst_n, .spi(badLink), .cfgWords(badWords), .divideModeSelect(),
        .intRatio(), .fractionModulus(), .fracNumerator(), .loopEnable(), .allWritten(),
        .wordLoaded(badLoaded), .frameError(badError));
    pdr_sva pdr_sva_i (.clk, .rst_n, .sclk(link.sclk), .sdata(link.sdata), .le(link.le),
        .wordLoaded, .frameError);

    always #(CLK_PERIOD_NS / 2) clk = ~clk;

    // ==========================================
    // helpers
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic final_report;
        if (bad_count == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic hang;
        chk("wait", 1'h1, 1'h0);
        final_report();
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        psel    <= 1'h1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'h1;
        for (int n = 0; n < 20; n++)
        begin
            @(posedge clk);
            if (pready === 1'h1)
                break;
        end
        if (pready !== 1'h1)
            hang();
        q = prdata;
        e = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
        @(posedge clk);
    endtask

    task automatic rdStat(output logic [31:0] s);
        logic e;
        apb(1'h0, HOST_STAT_OFS, 32'h0000_0000, s, e);
    endtask

    function automatic logic [23:0] wd(input logic [2:0] s, input logic [10:0] v);
        return {10'h000, v, s};
    endfunction

    task automatic checkRegs;
        for (int k = 0; k < NUM_REGS; k++)
            chk("cfgWords", expW[k], cfgWords[k]);
        chk("divideMode", expW[0][DM_BIT], divideModeSelect);
        chk("intRatio", expW[0][RATIO_MSB:RATIO_LSB], intRatio);
        chk("modulus", expW[1][MOD_MSB:MOD_LSB], fractionModulus);
        chk("numerator", expW[2][FRAC_MSB:FRAC_LSB], fracNumerator);
        chk("loopEnable", |expW[6][VCO_EN_MSB:VCO_EN_LSB], loopEnable);
    endtask

    task automatic waitDone(input logic ld);
        logic [31:0] s;
        logic        seen;
        seen = 1'h0;
        for (int n = 0; n < 260 && !(seen && ld); n++)
        begin
            @(posedge clk);
            seen |= wordLoaded === 1'h1;
        end
        chk("wordLoaded", ld, seen);
        s = 32'h0000_0001;
        for (int n = 0; n < 20 && s[ST_BUSY] !== 1'h0; n++)
            rdStat(s);
        if (s[ST_BUSY] !== 1'h0)
            hang();
    endtask

    task automatic tryWord(input logic [23:0] w, input logic ok);
        logic [31:0] s;
        logic        e;
        apb(1'h1, HOST_WORD_OFS, {8'h00, w}, s, e);
        chk("pslverr", 1'h0, e);
        waitDone(ok);
        if (ok)
            expW[w[2:0]] = w[2:0] == SEL_INT ? w & 24'h00_07FF : w;
        rdStat(s);
        chk("rangeErr", !ok, s[ST_RANGE_ERR]);
        checkRegs();
        apb(1'h1, HOST_STAT_OFS, 32'h0000_000C, s, e);
    endtask

    task automatic tryRatio(input logic dm, input logic [6:0] r, input logic ok);
        tryWord(wd(SEL_INT, 11'({dm, r})), ok);
    endtask

    task automatic shiftBad(input logic [23:0] w, input int nb);
        logic err;
        logic ld;
        err = 1'h0;
        ld  = 1'h0;
        for (int i = 0; i < nb; i++)
        begin
            badLink.sdata <= w[23 - (i % 24)];
            repeat (HALF_CYCLES) @(posedge clk);
            badLink.sclk <= 1'h1;
            repeat (HALF_CYCLES) @(posedge clk);
            badLink.sclk <= 1'h0;
        end
        badLink.le <= 1'h1;
        for (int i = 0; i < 12; i++)
        begin
            @(posedge clk);
            badLink.le <= i < HALF_LAST;
            err |= badError === 1'h1;
            ld  |= badLoaded === 1'h1;
        end
        // released data line shows the inverse of its last bit
        badLink.sdata <= ~badLink.sdata;
        chk("frameError", nb != 24, err);
        chk("wordLoaded", nb == 24, ld);
        chk("cfgWords", nb == 24 ? w : RST_EXTVCO, badWords[7]);
        @(posedge clk);
    endtask

    // ==========================================
    // scenarios
    task automatic tDefaults;
        logic [31:0] s;
        expW = {RST_EXTVCO, RST_VCO, RST_LOPATH, RST_CHARGE, RST_DITHER, RST_FRAC, RST_MOD, RST_INT};
        checkRegs();
        rdStat(s);
        chk("status", 5'h00, s[4:0]);
        chk("allWritten", 1'h0, allWritten);
    endtask

    task automatic tFirstPass;
        logic [31:0] s;
        for (int k = 7; k >= 0; k--)
        begin
            chk("allWritten", 1'h0, allWritten);
            tryWord(k == 0 ? 24'h00_0200 : k == 1 ? 24'h00_1F41 : k == 2 ? 24'h00_0F9A :
                {4'hA, 1'h0, 3'(k), 13'h0155, 3'(k)}, 1'h1);
        end
        chk("allWritten", 1'h1, allWritten);
        rdStat(s);
        chk("passDone", 1'h1, s[ST_INIT_DONE]);
        chk("orderErr", 1'h0, s[ST_ORDER_ERR]);
    endtask

    task automatic tRanges;
        tryRatio(1'h1, 7'h15, 1'h1);
        tryRatio(1'h1, 7'h7B, 1'h1);
        tryRatio(1'h1, 7'h14, 1'h0);
        tryRatio(1'h1, 7'h7C, 1'h0);
        tryRatio(1'h0, 7'h18, 1'h1);
        tryRatio(1'h0, 7'h77, 1'h1);
        tryRatio(1'h0, 7'h17, 1'h0);
        tryRatio(1'h0, 7'h78, 1'h0);
        tryWord(wd(SEL_MOD, 11'h000), 1'h0);
        tryWord(wd(SEL_MOD, 11'h7FF), 1'h1);
        tryWord(wd(SEL_FRAC, 11'h7FF), 1'h0);
        tryWord(wd(SEL_FRAC, 11'h7FE), 1'h1);
        tryWord(24'hFF_FA00, 1'h1);
    endtask

    task automatic tLoop;
        logic [31:0] s;
        tryWord(24'h01_0006, 1'h1);
        rdStat(s);
        chk("loopOff", 1'h1, s[ST_LOOP_OFF]);
        tryWord(24'h02_0006, 1'h1);
        rdStat(s);
        chk("loopOff", 1'h0, s[ST_LOOP_OFF]);
    endtask

    task automatic tRefuse;
        logic [31:0] s;
        logic        e;
        apb(1'h1, HOST_WORD_OFS, 32'h0012_3455, s, e);
        apb(1'h1, HOST_WORD_OFS, 32'h0000_0005, s, e);
        chk("pslverr", 1'h1, e);
        apb(1'h0, 8'h08, 32'h0000_0000, s, e);
        chk("pslverr", 1'h1, e);
        chk("prdata", 32'h0000_0000, s);
        waitDone(1'h1);
        expW[5] = 24'h12_3455;
        checkRegs();
        rdStat(s);
        chk("orderErr", 1'h0, s[ST_ORDER_ERR]);
    endtask

    task automatic tReorder;
        logic [31:0] s;
        logic        e;
        // reset again mid-run, then break the descending first pass
        rst_n <= 1'h0;
        repeat (2) @(posedge clk);
        rst_n <= 1'h1;
        tDefaults();
        apb(1'h1, HOST_WORD_OFS, 32'h0000_0200, s, e);
        chk("pslverr", 1'h0, e);
        waitDone(1'h1);
        expW[0] = 24'h00_0200;
        checkRegs();
        rdStat(s);
        chk("orderErr", 1'h1, s[ST_ORDER_ERR]);
        chk("passDone", 1'h0, s[ST_INIT_DONE]);
        apb(1'h1, HOST_STAT_OFS, 32'h0000_0008, s, e);
        rdStat(s);
        chk("orderErr", 1'h0, s[ST_ORDER_ERR]);
    endtask

    // ==========================================
    // main sequence
    initial
    begin
        clk           = 1'h0;
        rst_n         = 1'h0;
        psel          = 1'h0;
        penable       = 1'h0;
        pwrite        = 1'h0;
        paddr         = 8'h00;
        pwdata        = 32'h0000_0000;
        badLink.sclk  = 1'h0;
        badLink.sdata = 1'h0;
        badLink.le    = 1'h0;
        repeat (12) @(posedge clk);
        rst_n <= 1'h1;
        tDefaults();
        tFirstPass();
        tRanges();
        tLoop();
        tRefuse();
        shiftBad(24'h5A_A5A7, 23);
        shiftBad(24'h5A_A5A7, 25);
        shiftBad(24'h5A_A5A7, 24);
        tReorder();
        final_report();
    end
endmodule
